// ### core/mps_slave.sv
// parameter access slave: decodes requests, drives parameter port, builds answers
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"

// How it works
// - address byte only; own address 1-247
// - answer carries our own node address
// - failed valid request answers exception code
// - bad check or line error: stay silent
// - check field: crc rtu, lrc ascii
// - multi-byte fields except the crc travel high byte first
// - codes 3 and 6 serve 16-bit access
// - codes 100 and 101 serve 32-bit access
// - diagnostics code 8 accepted
// - read16: address, count must be one
// - read16 answer: code, count two, value
// - read16 bad count or unknown: 0x83, 2
// - address: parameter low 12, set high 4
// - scaled integers pass through unchanged
// - read: length error 3, failure 4
// - write16 success echoes the request
// - write16 fails: 0x86 with 2, 3, 4
// - read32 request: 0x64 plus address
// - read32 answer four bytes, error 0xE4
// - write32 0x65 echoes, error 0xE5
// - address zero: writes only, never answered
module mps_slave (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ascii_mode,
   input wire logic [7:0] own_addr,
   input wire mps_pkg::mps_rx_t rx,
   input wire logic tx_ready,
   output mps_pkg::mps_tx_t tx,
   output mps_pkg::mps_prm_req_t prm_req,
   input wire mps_pkg::mps_prm_ans_t prm_ans
);
   import mps_pkg::*;

   // all block state outside the two check units lives in one register; nxt_r is its next value
   mps_core_t r_ff;
   mps_core_t nxt_r;
   // strobes into the two check units
   logic rx_clr;
   logic rx_en;
   logic tx_clr;
   logic tx_en;
   // running check values, read at decode and in the gap beat
   logic [15:0] rx_chk;
   logic [15:0] tx_chk;

   // incoming frame check; a whole frame including its check sums to zero
   mps_check u_rx_chk (
      .core_clk(core_clk),
      .rstn(rstn),
      .clear(rx_clr),
      .en(rx_en),
      .ascii(ascii_mode),
      .data(rx.data),
      .chk(rx_chk)
   );

   // outgoing check, fed only with answer bytes the link has taken
   mps_check u_tx_chk (
      .core_clk(core_clk),
      .rstn(rstn),
      .clear(tx_clr),
      .en(tx_en),
      .ascii(ascii_mode),
      .data(r_ff.tx.data),
      .chk(tx_chk)
   );

   // load the first answer byte and start streaming
   function automatic mps_core_t start_send(input mps_core_t s, input logic [3:0] len);
      s.rlen = len;
      s.idx = 4'h0;
      s.tx.valid = 1'b1;
      s.tx.last = 1'b0;
      s.tx.data = s.buff[0];
      s.state = st_send;
      return s;
   endfunction : start_send

   // exception answer: own address, code with top bit, reason
   function automatic mps_core_t except(input mps_core_t s, input logic [7:0] own,
                                        input logic [7:0] code);
      s.buff[0] = own;
      s.buff[1] = s.fc | `MPS_FC_ERR;
      s.buff[2] = code;
      s.diag[2] = 16'(s.diag[2] + 16'h0001);
      return start_send(s, 4'h3);
   endfunction : except

   // frame judge and answer builder, one pass per cycle
   // length is judged before the address range, so a short frame with a bad
   // address reports a length error; the master sees one reason only
   always_comb begin
      logic [1:0] ckl;
      logic [3:0] dl;
      logic ck_ok;
      logic hit;
      logic [15:0] pa;
      logic [15:0] w45;
      logic range_bad;
      logic go;
      logic [7:0] ex;
      logic [15:0] sub;
      logic [15:0] dval;
      ckl = ascii_mode ? 2'd1 : 2'd2;
      dl = 4'(r_ff.cnt - 4'h2 - {2'b00, ckl});
      ck_ok = ascii_mode ? (rx_chk[7:0] == 8'h00) : (rx_chk == 16'h0000);
      hit = (r_ff.buff[0] == own_addr) && (own_addr != `MPS_BCAST_ADDR)
            && (own_addr <= `MPS_MAX_NODE);
      pa = {r_ff.buff[2], r_ff.buff[3]};
      w45 = {r_ff.buff[4], r_ff.buff[5]};
      range_bad = (pa[`MPS_PNUM_MSB:0] > `MPS_MAX_PNUM) ||
                  (pa[15:`MPS_DSET_LSB] > `MPS_MAX_DSET);
      go = 1'b0;
      ex = 8'h00;
      sub = pa;
      dval = 16'h0000;
      nxt_r = r_ff;
      rx_clr = 1'b0;
      rx_en = 1'b0;
      tx_clr = 1'b0;
      tx_en = 1'b0;
      case (r_ff.state)
         // wait for the first byte of a frame
         st_idle: begin
            if (rx.valid && rx.sof) begin
               rx_clr = 1'b1;
               rx_en = 1'b1;
               nxt_r.buff[0] = rx.data;
               nxt_r.cnt = 4'h1;
               nxt_r.state = st_recv;
            end
         end
         // gather bytes; extra bytes still feed the check but are not kept
         st_recv: begin
            if (rx.valid) begin
               rx_en = 1'b1;
               rx_clr = rx.sof;
               if (rx.sof) begin
                  nxt_r.buff[0] = rx.data;
                  nxt_r.cnt = 4'h1;
               end else begin
                  if (r_ff.cnt < 4'(`MPS_BUF_BYTES)) begin
                     nxt_r.buff[r_ff.cnt] = rx.data;
                  end
                  if (r_ff.cnt != `MPS_CNT_MAX) begin
                     nxt_r.cnt = 4'(r_ff.cnt + 4'h1);
                  end
               end
            end
            if (rx.eof) begin
               nxt_r.err = rx.err;
               nxt_r.state = st_decode;
            end
         end
         // judge the frame and pick the action
         st_decode: begin
            nxt_r.fc = r_ff.buff[1];
            nxt_r.bcast = (r_ff.buff[0] == `MPS_BCAST_ADDR);
            nxt_r.state = st_idle;
            // damaged or short frames only bump the error counter
            if (r_ff.err || !ck_ok || (r_ff.cnt < 4'({2'b00, ckl} + 4'h2))) begin
               nxt_r.diag[1] = 16'(r_ff.diag[1] + 16'h0001);
            end else begin
               nxt_r.diag[0] = 16'(r_ff.diag[0] + 16'h0001);
               if (hit || nxt_r.bcast) begin
                  if (nxt_r.bcast) begin
                     nxt_r.diag[4] = 16'(r_ff.diag[4] + 16'h0001);
                  end else begin
                     nxt_r.diag[3] = 16'(r_ff.diag[3] + 16'h0001);
                  end
                  // target fields load even when no access follows; req stays low then
                  nxt_r.prm.dset = pa[15:`MPS_DSET_LSB];
                  nxt_r.prm.num = pa[`MPS_PNUM_MSB:0];
                  nxt_r.prm.wdata = {16'h0000, w45};
                  case (r_ff.buff[1])
                     `MPS_FC_RD16: begin
                        if (dl != `MPS_LEN_RD16) ex = `MPS_EX_VALUE;
                        else if (w45 != `MPS_REG_CNT1 || range_bad) ex = `MPS_EX_ADDR;
                        else go = 1'b1;
                        nxt_r.prm.we = 1'b0;
                        nxt_r.prm.wide = 1'b0;
                     end
                     `MPS_FC_WR16: begin
                        if (dl != `MPS_LEN_WR16) ex = `MPS_EX_VALUE;
                        else if (range_bad) ex = `MPS_EX_ADDR;
                        else go = 1'b1;
                        nxt_r.prm.we = 1'b1;
                        nxt_r.prm.wide = 1'b0;
                     end
                     `MPS_FC_RD32: begin
                        if (dl != `MPS_LEN_RD32) ex = `MPS_EX_VALUE;
                        else if (range_bad) ex = `MPS_EX_ADDR;
                        else go = 1'b1;
                        nxt_r.prm.we = 1'b0;
                        nxt_r.prm.wide = 1'b1;
                     end
                     `MPS_FC_WR32: begin
                        if (dl != `MPS_LEN_WR32) ex = `MPS_EX_VALUE;
                        else if (range_bad) ex = `MPS_EX_ADDR;
                        else go = 1'b1;
                        nxt_r.prm.we = 1'b1;
                        nxt_r.prm.wide = 1'b1;
                        nxt_r.prm.wdata = {w45, r_ff.buff[6], r_ff.buff[7]};
                     end
                     `MPS_FC_DIAG: begin
                        if (sub != `MPS_DIAG_CLR &&
                            (sub < `MPS_DIAG_FIRST || sub > `MPS_DIAG_LAST)) begin
                           ex = `MPS_EX_FUNC;
                        end else if (dl != `MPS_LEN_DIAG || w45 != 16'h0000) begin
                           ex = `MPS_EX_VALUE;
                        end
                     end
                     // any other function code is refused with code 1
                     default: ex = `MPS_EX_FUNC;
                  endcase
                  if (nxt_r.bcast) begin
                     // broadcast: only a clean write runs, and nothing answers
                     if (go && nxt_r.prm.we) begin
                        nxt_r.prm.req = 1'b1;
                        nxt_r.state = st_param;
                     end
                  end else if (ex != 8'h00) begin
                     nxt_r = except(nxt_r, own_addr, ex);
                     tx_clr = 1'b1;
                  end else if (go) begin
                     nxt_r.prm.req = 1'b1;
                     nxt_r.state = st_param;
                  end else begin
                     // diagnostics: counter value or clear, echoed with sub code
                     // counters wrap at 16 bits; nothing saturates
                     if (sub >= `MPS_DIAG_FIRST && sub < 16'(`MPS_DIAG_FIRST + 16'h0005)) begin
                        dval = nxt_r.diag[3'(sub - `MPS_DIAG_FIRST)];
                     end
                     if (sub == `MPS_DIAG_CLR) begin
                        nxt_r.diag = '0;
                     end
                     nxt_r.buff[0] = own_addr;
                     nxt_r.buff[4] = dval[15:8];
                     nxt_r.buff[5] = dval[7:0];
                     nxt_r = start_send(nxt_r, 4'h6);
                     tx_clr = 1'b1;
                  end
               end
            end
         end
         // request held to the drive until it acknowledges
         // a status other than ok turns the answer into an exception
         st_param: begin
            if (prm_ans.ack) begin
               nxt_r.prm.req = 1'b0;
               nxt_r.state = st_idle;
               if (r_ff.bcast) begin
                  nxt_r.state = st_idle;
               end else if (prm_ans.status == prm_unknown) begin
                  nxt_r = except(nxt_r, own_addr, `MPS_EX_ADDR);
                  tx_clr = 1'b1;
               end else if (prm_ans.status == prm_fail) begin
                  nxt_r = except(nxt_r, own_addr, `MPS_EX_FAIL);
                  tx_clr = 1'b1;
               end else begin
                  nxt_r.buff[0] = own_addr;
                  tx_clr = 1'b1;
                  case (r_ff.fc)
                     `MPS_FC_RD16: begin
                        nxt_r.buff[2] = `MPS_BYTE_CNT16;
                        nxt_r.buff[3] = prm_ans.rdata[15:8];
                        nxt_r.buff[4] = prm_ans.rdata[7:0];
                        nxt_r = start_send(nxt_r, 4'h5);
                     end
                     `MPS_FC_RD32: begin
                        nxt_r.buff[2] = prm_ans.rdata[31:24];
                        nxt_r.buff[3] = prm_ans.rdata[23:16];
                        nxt_r.buff[4] = prm_ans.rdata[15:8];
                        nxt_r.buff[5] = prm_ans.rdata[7:0];
                        nxt_r = start_send(nxt_r, 4'h6);
                     end
                     `MPS_FC_WR32: nxt_r = start_send(nxt_r, 4'h8);
                     default: nxt_r = start_send(nxt_r, 4'h6);
                  endcase
               end
            end
         end
         // answer bytes, one per accepted beat
         // the check unit takes a byte only on a beat with tx_ready high
         st_send: begin
            if (tx_ready) begin
               tx_en = 1'b1;
               if (r_ff.idx == 4'(r_ff.rlen - 4'h1)) begin
                  nxt_r.tx.valid = 1'b0;
                  nxt_r.state = st_gap;
               end else begin
                  nxt_r.idx = 4'(r_ff.idx + 4'h1);
                  nxt_r.tx.data = r_ff.buff[4'(r_ff.idx + 4'h1)];
               end
            end
         end
         // one idle beat lets the check unit settle before its bytes go out
         // by now the last answer byte has entered the running check
         st_gap: begin
            nxt_r.tx.valid = 1'b1;
            nxt_r.tx.last = ascii_mode;
            nxt_r.tx.data = ascii_mode ? 8'(8'h00 - tx_chk[7:0]) : tx_chk[7:0];
            nxt_r.ck_hi = tx_chk[15:8];
            nxt_r.state = st_check;
         end
         // crc goes low byte then high; lrc is a single byte
         st_check: begin
            if (tx_ready) begin
               if (r_ff.tx.last) begin
                  nxt_r.tx.valid = 1'b0;
                  nxt_r.tx.last = 1'b0;
                  nxt_r.state = st_idle;
               end else begin
                  nxt_r.tx.data = r_ff.ck_hi;
                  nxt_r.tx.last = 1'b1;
               end
            end
         end
         default: nxt_r.state = st_idle;
      endcase
   end

   // reset drops any pending access and silences the answer stream
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // outputs come straight from the state register
   assign tx = r_ff.tx;
   assign prm_req = r_ff.prm;
endmodule : mps_slave

`default_nettype wire

// ### core/mps_defs.svh
// constants of the parameter slave: codes, field positions, lengths, check seeds
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

`define MPS_FC_RD16 8'h03
`define MPS_FC_WR16 8'h06
`define MPS_FC_DIAG 8'h08
`define MPS_FC_RD32 8'h64
`define MPS_FC_WR32 8'h65
`define MPS_FC_ERR 8'h80
`define MPS_EX_FUNC 8'h01
`define MPS_EX_ADDR 8'h02
`define MPS_EX_VALUE 8'h03
`define MPS_EX_FAIL 8'h04
`define MPS_BCAST_ADDR 8'h00
`define MPS_MAX_NODE 8'hF7
`define MPS_BYTE_CNT16 8'h02
`define MPS_REG_CNT1 16'h0001
`define MPS_MAX_PNUM 12'h063F
`define MPS_MAX_DSET 4'h9
`define MPS_PNUM_MSB 11
`define MPS_DSET_LSB 12
`define MPS_DIAG_CLR 16'h000A
`define MPS_DIAG_FIRST 16'h000B
`define MPS_DIAG_LAST 16'h0012
`define MPS_DIAG_CNTS 5
`define MPS_LEN_RD16 4'h4
`define MPS_LEN_WR16 4'h4
`define MPS_LEN_RD32 4'h2
`define MPS_LEN_WR32 4'h6
`define MPS_LEN_DIAG 4'h4
`define MPS_BUF_BYTES 10
`define MPS_CNT_MAX 4'hF
`define MPS_CRC_INIT 16'hFFFF
`define MPS_CRC_POLY 16'hA001

`endif

// ### core/mps_pkg.sv
// types shared by the parameter slave and its check-field unit
package mps_pkg;
`include "mps_defs.svh"

   typedef enum logic [2:0] {
      st_idle, st_recv, st_decode, st_param, st_send, st_gap, st_check
   } mps_state_t;

   typedef enum logic [1:0] {prm_ok, prm_unknown, prm_fail} mps_prm_sts_t;

   // byte stream from the character framing layer
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic err;
      logic [7:0] data;
   } mps_rx_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } mps_tx_t;

   typedef struct packed {
      logic req;
      logic we;
      logic wide;
      logic [3:0] dset;
      logic [11:0] num;
      logic [31:0] wdata;
   } mps_prm_req_t;

   typedef struct packed {
      logic ack;
      mps_prm_sts_t status;
      logic [31:0] rdata;
   } mps_prm_ans_t;

   typedef struct packed {
      mps_state_t state;
      logic [`MPS_BUF_BYTES-1:0][7:0] buff;
      logic [3:0] cnt;
      logic [3:0] idx;
      logic [3:0] rlen;
      logic [7:0] fc;
      logic err;
      logic bcast;
      logic [7:0] ck_hi;
      logic [`MPS_DIAG_CNTS-1:0][15:0] diag;
      mps_prm_req_t prm;
      mps_tx_t tx;
   } mps_core_t;

   typedef struct packed {
      logic [15:0] chk;
   } mps_chk_st_t;
endpackage : mps_pkg

// ### core/mps_check.sv
// running check field: crc in rtu mode, byte sum in ascii mode
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"

module mps_check (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clear,
   input wire logic en,
   input wire logic ascii,
   input wire logic [7:0] data,
   output logic [15:0] chk
);
   import mps_pkg::*;

   mps_chk_st_t r_ff;
   mps_chk_st_t nxt_r;

   // clear and a byte in the same cycle start a fresh sum with that byte
   always_comb begin
      logic [15:0] base;
      base = clear ? (ascii ? 16'h0000 : `MPS_CRC_INIT) : r_ff.chk;
      nxt_r.chk = base;
      if (en) begin
         if (ascii) begin
            nxt_r.chk = {8'h00, base[7:0] + data};
         end else begin
            nxt_r.chk = base ^ {8'h00, data};
            for (int b = 0; b < 8; b++) begin
               nxt_r.chk = nxt_r.chk[0] ? ((nxt_r.chk >> 1) ^ `MPS_CRC_POLY) : (nxt_r.chk >> 1);
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '{chk: `MPS_CRC_INIT};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign chk = r_ff.chk;
endmodule : mps_check

`default_nettype wire

// ### testbench/mps_slave_chk.sv
// port assertions for the parameter slave, bound onto its top module
`timescale 1ns/1ps
`default_nettype none
module mps_slave_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ascii_mode,
   input wire logic [7:0] own_addr,
   input wire mps_pkg::mps_rx_t rx,
   input wire logic tx_ready,
   input wire mps_pkg::mps_tx_t tx,
   input wire mps_pkg::mps_prm_req_t prm_req,
   input wire mps_pkg::mps_prm_ans_t prm_ans
);
   import mps_pkg::*;
   logic [3:0] cnt_ff;
   logic [7:0] fc_ff;
   logic [7:0] adr_ff;
   wire logic acc = tx.valid && tx_ready;
   // answer byte position, answer code, request address; rebuilt from the wires only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 4'h0;
         fc_ff <= 8'h00;
         adr_ff <= 8'h00;
      end else begin
         if (acc) cnt_ff <= tx.last ? 4'h0 : cnt_ff + 4'h1;
         if (acc && cnt_ff == 4'h1) fc_ff <= tx.data;
         if (rx.valid && rx.sof) adr_ff <= rx.data;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_addr_first: assert property (tx.valid && cnt_ff == 4'h0 |-> tx.data == own_addr)
      else $error("answer does not open with node address");
   a_exc_code: assert property (tx.valid && cnt_ff == 4'h2 && fc_ff[7] |->
      tx.data inside {8'h01, 8'h02, 8'h03, 8'h04}) else $error("bad exception code");
   a_rd16_count: assert property (tx.valid && cnt_ff == 4'h2 && fc_ff == 8'h03 |->
      tx.data == 8'h02) else $error("read answer byte count not two");
   a_req_start: assert property ($rose(prm_req.req) |-> $past(rx.eof, 2))
      else $error("access started off its slot");
   a_req_hold: assert property (prm_req.req && !prm_ans.ack |=> prm_req.req &&
      $stable(prm_req.num) && $stable(prm_req.dset)) else $error("access target moved");
   a_req_drop: assert property (prm_req.req && prm_ans.ack |=> !prm_req.req)
      else $error("access held after ack");
   a_bad_silent: assert property (rx.eof && rx.err |=> (!tx.valid && !prm_req.req)[*8])
      else $error("damaged frame acted on");
   a_bcast_quiet: assert property (rx.eof && adr_ff == 8'h00 |=> (!tx.valid)[*8])
      else $error("broadcast answered");
   a_foreign_quiet: assert property (rx.eof && adr_ff != 8'h00 && adr_ff != own_addr
      |=> (!tx.valid && !prm_req.req)[*8]) else $error("foreign frame acted on");
   a_end_idle: assert property (acc && tx.last |=> !tx.valid)
      else $error("bytes after check field");
   a_tx_stall: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
      else $error("stalled byte changed");
   c_access: cover property (prm_req.req && prm_ans.ack);
   c_exc_done: cover property (acc && tx.last && fc_ff[7]);
   c_stall: cover property (tx.valid && !tx_ready);
endmodule : mps_slave_chk
bind mps_slave mps_slave_chk mps_slave_chk_i (.core_clk(core_clk), .rstn(rstn),
   .ascii_mode(ascii_mode), .own_addr(own_addr), .rx(rx), .tx_ready(tx_ready), .tx(tx),
   .prm_req(prm_req), .prm_ans(prm_ans));
`default_nettype wire

// ### testbench/mps_link_sink.sv
// answer sink standing for the bus master, prompt or slow in taking bytes
`timescale 1ns/1ps
`default_nettype none
module mps_link_sink (
   input wire logic core_clk,
   input wire logic slow,
   input wire mps_pkg::mps_tx_t tx,
   output logic tx_ready
);
   import mps_pkg::*;
   logic [7:0] got[$];
   logic ph = 1'b0;
   // slow mode takes every other cycle so held bytes are exercised
   always @(posedge core_clk) begin
      if (tx.valid && tx_ready) got.push_back(tx.data);
      ph <= !ph;
      #2 tx_ready = !slow || ph;
   end
endmodule : mps_link_sink
`default_nettype wire

// ### testbench/tb_modbus_parameter_slave.sv
// self-checking bench for the parameter slave
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"
module tb_modbus_parameter_slave;
   import mps_pkg::*;
   typedef logic [7:0] mps_bq_t[$];
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic ascii_mode = 1'b0;
   logic [7:0] own_addr = 8'h11;
   logic slow = 1'b0;
   mps_rx_t rx = '0;
   logic tx_ready;
   mps_tx_t tx;
   mps_prm_req_t prm_req;
   mps_prm_ans_t prm_ans = '0;
   mps_prm_req_t last_req = '0;
   int n_fail = 0;
   int n_checks = 0;
   int n_acc = 0;
   int dly = 1;
   always #25 core_clk = !core_clk;
   mps_slave mps_slave_i (.core_clk(core_clk), .rstn(rstn), .ascii_mode(ascii_mode),
      .own_addr(own_addr), .rx(rx), .tx_ready(tx_ready), .tx(tx), .prm_req(prm_req),
      .prm_ans(prm_ans));
   mps_link_sink mps_link_sink_i (.core_clk(core_clk), .slow(slow), .tx(tx),
      .tx_ready(tx_ready));
   // parameter store: numbers 0x100 and 0x200 stand for unknown and failing ones
   always @(posedge core_clk) begin
      #2;
      if (prm_ans.ack) prm_ans = '0;
      else if (prm_req.req && dly > 0) dly--;
      else if (prm_req.req) begin
         prm_ans.status = prm_req.num == 12'h100 ? prm_unknown :
            (prm_req.num == 12'h200 ? prm_fail : prm_ok);
         prm_ans.rdata = {20'hA_BCDE, prm_req.num};
         prm_ans.ack = 1'b1;
         last_req = prm_req;
         n_acc++;
         dly = slow ? 3 : 1;
      end
   end
   task automatic fail(string m);
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : fail
   task automatic chk(bit ok, string m);
      n_checks++;
      if (!ok) fail(m);
   endtask : chk
   // crc low byte first in rtu, two's complement byte sum in ascii
   function automatic mps_bq_t with_chk(mps_bq_t q);
      logic [15:0] c;
      logic [7:0] s;
      c = `MPS_CRC_INIT;
      s = 8'h00;
      foreach (q[i]) begin
         s = s + q[i];
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ `MPS_CRC_POLY : c >> 1;
      end
      if (ascii_mode) q.push_back(8'h00 - s);
      else begin
         q.push_back(c[7:0]);
         q.push_back(c[15:8]);
      end
      return q;
   endfunction : with_chk
   // one request to address a, then the whole answer compared; empty e means silence
   task automatic xact(logic [7:0] a, mps_bq_t q, mps_bq_t e, bit bad = 1'b0, bit err = 1'b0);
      int k;
      bit ok;
      q.push_front(a);
      q = with_chk(q);
      if (bad) q[q.size() - 1] ^= 8'h01;
      if (e.size() > 0) e.push_front(own_addr);
      if (e.size() > 0) e = with_chk(e);
      mps_link_sink_i.got.delete();
      foreach (q[i]) begin
         @(posedge core_clk);
         #2 rx = '{1'b1, i == 0, 1'b0, 1'b0, q[i]};
      end
      @(posedge core_clk);
      #2 rx = '{1'b0, 1'b0, 1'b1, err, 8'h00};
      @(posedge core_clk);
      #2 rx = '0;
      for (k = 0; k < 300 && (e.size() == 0 || mps_link_sink_i.got.size() < e.size()); k++)
         @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      ok = mps_link_sink_i.got.size() == e.size();
      foreach (e[i]) if (ok && mps_link_sink_i.got[i] !== e[i]) ok = 1'b0;
      chk(ok, "answer bytes differ");
   endtask : xact
   task automatic t_access();
      mps_bq_t q;
      xact(8'h11, '{8'h03, 8'h21, 8'h74, 8'h00, 8'h01}, '{8'h03, 8'h02, 8'hE1, 8'h74});
      chk({last_req.we, last_req.wide, last_req.dset, last_req.num} === 18'h0_2174, "rd");
      xact(8'h11, '{8'h03, 8'h96, 8'h3F, 8'h00, 8'h01}, '{8'h03, 8'h02, 8'hE6, 8'h3F});
      q = '{8'h06, 8'h00, 8'h05, 8'h27, 8'h29};
      xact(8'h11, q, q);
      chk({last_req.we, last_req.wide, last_req.wdata[15:0]} === 18'h2_2729, "wr16");
      xact(8'h11, '{8'h64, 8'h00, 8'h07}, '{8'h64, 8'hAB, 8'hCD, 8'hE0, 8'h07});
      chk({last_req.we, last_req.wide} === 2'b01, "rd32 kind");
      #2 slow = 1'b1;
      q = '{8'h65, 8'h93, 8'h00, 8'hDE, 8'hAD, 8'hBE, 8'hEF};
      xact(8'h11, q, q);
      chk({last_req.we, last_req.wide, last_req.wdata} === 34'h3_DEAD_BEEF, "wr32");
      #2 slow = 1'b0;
      $display("test access done");
   endtask : t_access
   task automatic t_exc();
      xact(8'h11, '{8'h03, 8'h00, 8'h05, 8'h00, 8'h02}, '{8'h83, 8'h02});
      xact(8'h11, '{8'h03, 8'h06, 8'h40, 8'h00, 8'h01}, '{8'h83, 8'h02});
      xact(8'h11, '{8'h03, 8'hA0, 8'h05, 8'h00, 8'h01}, '{8'h83, 8'h02});
      xact(8'h11, '{8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, '{8'h83, 8'h02});
      xact(8'h11, '{8'h03, 8'h02, 8'h00, 8'h00, 8'h01}, '{8'h83, 8'h04});
      xact(8'h11, '{8'h03, 8'h00, 8'h05, 8'h00}, '{8'h83, 8'h03});
      xact(8'h11, '{8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, '{8'h86, 8'h02});
      xact(8'h11, '{8'h06, 8'h02, 8'h00, 8'h00, 8'h01}, '{8'h86, 8'h04});
      xact(8'h11, '{8'h06, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00}, '{8'h86, 8'h03});
      xact(8'h11, '{8'h64, 8'h02, 8'h00}, '{8'hE4, 8'h04});
      xact(8'h11, '{8'h65, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'hE5, 8'h02});
      xact(8'h11, '{8'h11, 8'h00, 8'h00}, '{8'h91, 8'h01});
      $display("test exceptions done");
   endtask : t_exc
   task automatic t_diag();
      mps_bq_t q;
      q = '{8'h08, 8'h00, 8'h0A, 8'h00, 8'h00};
      xact(8'h11, q, q);
      q = '{8'h08, 8'h00, 8'h10, 8'h00, 8'h00};
      xact(8'h11, q, q);
      xact(8'h11, '{8'h08, 8'h00, 8'h13, 8'h00, 8'h00}, '{8'h88, 8'h01});
      xact(8'h11, '{8'h08, 8'h00, 8'h0B, 8'h00, 8'h01}, '{8'h88, 8'h03});
      q = '{8'h08, 8'h00, 8'h0D, 8'h00};
      xact(8'h11, '{8'h08, 8'h00, 8'h0D, 8'h00, 8'h00}, '{8'h08, 8'h00, 8'h0D, 8'h00, 8'h02});
      $display("test diagnostics done");
   endtask : t_diag
   task automatic t_silent();
      mps_bq_t rd;
      int n;
      rd = '{8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
      n = n_acc;
      xact(8'h11, rd, '{}, 1'b1, 1'b0);
      xact(8'h11, rd, '{}, 1'b0, 1'b1);
      xact(8'h12, rd, '{});
      xact(8'h00, '{8'h06, 8'h00, 8'h05, 8'h00, 8'h42}, '{});
      chk(n_acc == n + 1 && {last_req.we, last_req.wdata[15:0]} === 17'h1_0042, "bc");
      xact(8'h00, rd, '{});
      chk(n_acc == n + 1, "broadcast read accessed");
      #2 own_addr = 8'hF8;
      xact(8'hF8, rd, '{});
      #2 ascii_mode = 1'b1;
      own_addr = 8'hF7;
      xact(8'hF7, rd, '{8'h03, 8'h02, 8'hE0, 8'h05});
      #2 ascii_mode = 1'b0;
      own_addr = 8'h11;
      $display("test silence and ascii done");
   endtask : t_silent
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // main sequence after sixteen reset cycles
   initial begin
      repeat (16) @(posedge core_clk);
      #2 rstn = 1'b1;
      t_access();
      t_exc();
      t_diag();
      t_silent();
      test_done();
   end
   // watchdog well beyond the expected span of all transactions
   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail++;
      test_done();
   end
endmodule : tb_modbus_parameter_slave
`default_nettype wire
